// ===== src/timer_unit_regs.svh
// Register offsets, field positions, reset values and source codes.
`ifndef TIMER_UNIT_REGS_SVH
`define TIMER_UNIT_REGS_SVH

`define ADDR_W            8
`define REG_RUN           8'h00
`define REG_CTRL0         8'h04
`define REG_CTRL1         8'h08
`define REG_CTRL2         8'h0c
`define REG_RELOAD0       8'h10
`define REG_RELOAD1       8'h14
`define REG_RELOAD2       8'h18
`define REG_COUNT0        8'h1c
`define REG_COUNT1        8'h20
`define REG_COUNT2        8'h24
`define REG_CAPTURE2      8'h28
`define REG_IRQ_STATUS    8'h2c
`define REG_IRQ_CLEAR     8'h30
`define REG_IRQ_ENABLE    8'h34
`define REG_SOURCE_CODE   8'h38

`define CTRL_UNDERFLOW_IRQ_ENABLE_BIT     5
`define CTRL_UNF_BIT      8
`define CTRL_ICPF_BIT     9
`define CTRL_ICPE_LSB     6
`define CTRL_ICPIE_BIT    10
`define CTRL_SRC_LSB      0

`define COUNT_RESET       32'hffffffff
`define RELOAD_RESET      32'hffffffff

`define CODE_NONE         12'h000
`define CODE_UNDERFLOW0   12'h400
`define CODE_UNDERFLOW1   12'h420
`define CODE_UNDERFLOW2   12'h440
`define CODE_CAPTURE2     12'h460

`endif

// ===== src/timer_unit_pkg.sv
// Types shared by the timer unit files.
package timer_unit_pkg;
  typedef enum logic [1:0] {
    SRC_PCLK,
    SRC_PRESCALED,
    SRC_EXT_PIN,
    SRC_RTC
  } count_source_e;
  typedef enum logic [1:0] {
    CAP_OFF,
    CAP_RISE,
    CAP_FALL,
    CAP_RESERVED
  } capture_mode_e;
endpackage

// ===== src/timer_channel.sv
// One down-counting channel with auto-reload and underflow pulse.
`include "timer_unit_regs.svh"
module timer_channel #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             run_in,
  input  wire logic             tick_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] load_value_in,
  input  wire logic [WIDTH-1:0] reload_in,
  output logic      [WIDTH-1:0] count_out,
  output logic                  underflow_out
);
  logic step;

  assign step = run_in && tick_in;

  // Counter wraps to the reload value on the step that leaves zero.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_out <= `COUNT_RESET;
    end else if (load_in) begin
      count_out <= load_value_in;
    end else if (step) begin
      if (count_out == '0) begin
        count_out <= reload_in; // R11
      end else begin
        count_out <= count_out - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      underflow_out <= 1'b0;
    end else begin
      underflow_out <= step && !load_in && (count_out == '0); // R2
    end
  end
endmodule // timer_channel

// ===== src/timer_unit.sv
// Three-channel down-counting timer with interrupt and register access.
//
// Summary of operation
// R1 - Sources: three underflows plus channel-two capture.
// R2 - Wrap from zero sets channel underflow flag.
// R3 - Software clears a flag by writing zero.
// R4 - Request only while flag and enable set.
// R5 - Each channel has its own underflow request.
// R6 - Distinct source code shown for every request.
// R7 - Fixed priority: ch0, ch1, ch2, capture lowest.
// R8 - Writes unsynchronized; software halts channel first.
// R9 - Read during decrement returns pre-decrement value.
// R10 - RTC source: software uses special clear procedure.
// R11 - Underflow reloads constant and keeps counting.
// R12 - Pin capture copies channel-two counter value.
// R13 - Requests are levels; set beats clear.
`include "timer_unit_regs.svh"
module timer_unit #(
  parameter int WIDTH    = 32,
  parameter int PRESCALE = 4
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic [`ADDR_W-1:0]   addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 write_in,
  input  wire logic                 read_in,
  input  wire logic                 rtc_tick_in,
  input  wire logic                 timer_ext_pin_in,
  output logic      [31:0]          rdata_out,
  output logic                      underflow_irq_ch0_out,
  output logic                      underflow_irq_ch1_out,
  output logic                      underflow_irq_ch2_out,
  output logic                      capture_irq_ch2_out,
  output logic      [11:0]          exception_source_code_out,
  output logic                      irq_out
);
  localparam int NCH = 3;
  localparam int PW  = $clog2(PRESCALE + 1);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [NCH-1:0]   channel_run_bits;
  logic [NCH-1:0]   underflow_irq_enable;
  logic [NCH-1:0]   underflow_flag;
  logic [NCH-1:0]   underflow_pulse;
  logic [NCH-1:0]   ch_tick;
  logic [NCH-1:0]   count_load;
  logic [WIDTH-1:0] reload_constant_reg [NCH];
  logic [WIDTH-1:0] down_counter [NCH];
  timer_unit_pkg::count_source_e count_source [NCH];
  timer_unit_pkg::capture_mode_e capture_enable_bits;
  logic             capture_irq_enable;
  logic             capture_flag;
  logic [WIDTH-1:0] capture_value_reg;
  logic [3:0]       irq_status;
  logic [3:0]       irq_enable;
  logic [3:0]       irq_clear;
  logic [3:0]       irq_event;
  logic [3:0]       request;
  logic [PW-1:0]    prescale_count;
  logic             prescale_tick;
  logic             pin_meta;
  logic             pin_sync;
  logic             pin_prev;
  logic             pin_rise;
  logic             pin_fall;
  logic             capture_event;
  logic [11:0]      next_code;
  logic [31:0]      next_rdata;
  logic             wr_run;
  logic             wr_clear;
  logic             wr_enable;

  assign wr_run    = write_in && (addr_in == `REG_RUN);
  assign wr_clear  = write_in && (addr_in == `REG_IRQ_CLEAR);
  assign wr_enable = write_in && (addr_in == `REG_IRQ_ENABLE);

  // ------------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= timer_ext_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync && !pin_prev;
  assign pin_fall = !pin_sync && pin_prev;

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || prescale_tick) begin
      prescale_count <= '0;
    end else begin
      prescale_count <= prescale_count + PW'(1);
    end
  end

  assign prescale_tick = (prescale_count == PW'(PRESCALE - 1));

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      always_comb begin
        case (count_source[i])
          timer_unit_pkg::SRC_PCLK:      ch_tick[i] = 1'b1;
          timer_unit_pkg::SRC_PRESCALED: ch_tick[i] = prescale_tick;
          timer_unit_pkg::SRC_EXT_PIN:   ch_tick[i] = pin_rise;
          timer_unit_pkg::SRC_RTC:       ch_tick[i] = rtc_tick_in;
          default:                       ch_tick[i] = 1'b0;
        endcase
      end

      // No guard against a running channel: software halts it first.
      assign count_load[i] = write_in &&
                             (addr_in == `REG_COUNT0 + 8'(4 * i)); // R8

      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          reload_constant_reg[i] <= `RELOAD_RESET;
          count_source[i]        <= timer_unit_pkg::SRC_PCLK;
        end else if (write_in && addr_in == `REG_RELOAD0 + 8'(4 * i)) begin
          reload_constant_reg[i] <= wdata_in[WIDTH-1:0]; // R8
        end else if (write_in && addr_in == `REG_CTRL0 + 8'(4 * i)) begin
          count_source[i] <= timer_unit_pkg::count_source_e'(
                               wdata_in[`CTRL_SRC_LSB +: 2]);
        end
      end

      timer_channel #(
        .WIDTH (WIDTH)
      ) u_channel (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .run_in        (channel_run_bits[i]),
        .tick_in       (ch_tick[i]),
        .load_in       (count_load[i]),
        .load_value_in (wdata_in[WIDTH-1:0]),
        .reload_in     (reload_constant_reg[i]),
        .count_out     (down_counter[i]),
        .underflow_out (underflow_pulse[i])
      );

      // Set wins over a clear in the same cycle.
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          underflow_flag[i] <= 1'b0;
        end else if (irq_event[i]) begin
          underflow_flag[i] <= 1'b1; // R2 R13
        end else if ((write_in &&
                      addr_in == `REG_CTRL0 + 8'(4 * i) &&
                      !wdata_in[`CTRL_UNF_BIT]) ||
                     irq_clear[i]) begin
          underflow_flag[i] <= 1'b0; // R3
        end
      end

      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          underflow_irq_enable[i] <= 1'b0;
        end else if (write_in && addr_in == `REG_CTRL0 + 8'(4 * i)) begin
          underflow_irq_enable[i] <= wdata_in[`CTRL_UNDERFLOW_IRQ_ENABLE_BIT];
        end else if (wr_enable) begin
          underflow_irq_enable[i] <= wdata_in[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      channel_run_bits <= '0;
    end else if (wr_run) begin
      channel_run_bits <= wdata_in[NCH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Channel-two input capture
  // ------------------------------------------------------------------
  always_comb begin
    case (capture_enable_bits)
      timer_unit_pkg::CAP_RISE: capture_event = pin_rise;
      timer_unit_pkg::CAP_FALL: capture_event = pin_fall;
      default:                  capture_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      capture_enable_bits <= timer_unit_pkg::CAP_OFF;
      capture_irq_enable  <= 1'b0;
    end else if (write_in && addr_in == `REG_CTRL2) begin
      capture_enable_bits <= timer_unit_pkg::capture_mode_e'(
                               wdata_in[`CTRL_ICPE_LSB +: 2]);
      capture_irq_enable  <= wdata_in[`CTRL_ICPIE_BIT];
    end else if (wr_enable) begin
      capture_irq_enable  <= wdata_in[3];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      capture_value_reg <= '0;
    end else if (capture_event) begin
      capture_value_reg <= down_counter[2]; // R12
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      capture_flag <= 1'b0;
    end else if (irq_event[3]) begin
      capture_flag <= 1'b1; // R12 R13
    end else if ((write_in && addr_in == `REG_CTRL2 &&
                  !wdata_in[`CTRL_ICPF_BIT]) ||
                 irq_clear[3]) begin
      capture_flag <= 1'b0; // R3
    end
  end

  // ------------------------------------------------------------------
  // Interrupt requests, priority and source code
  // ------------------------------------------------------------------
  assign irq_status = {capture_flag, underflow_flag}; // R1
  assign irq_enable = {capture_irq_enable, underflow_irq_enable};
  assign irq_clear  = wr_clear ? wdata_in[3:0] : 4'h0;
  assign irq_event  = {capture_event, underflow_pulse};
  assign request    = irq_status & irq_enable; // R4

  assign underflow_irq_ch0_out = request[0]; // R5 R13
  assign underflow_irq_ch1_out = request[1]; // R5
  assign underflow_irq_ch2_out = request[2]; // R5
  assign capture_irq_ch2_out   = request[3];
  assign irq_out               = |request; // R4

  always_comb begin
    if (request[0]) begin
      next_code = `CODE_UNDERFLOW0; // R6 R7
    end else if (request[1]) begin
      next_code = `CODE_UNDERFLOW1; // R7
    end else if (request[2]) begin
      next_code = `CODE_UNDERFLOW2; // R7
    end else if (request[3]) begin
      next_code = `CODE_CAPTURE2; // R7
    end else begin
      next_code = `CODE_NONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      exception_source_code_out <= `CODE_NONE;
    end else begin
      exception_source_code_out <= next_code; // R6
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Counter value is sampled before this edge's decrement lands.
  always_comb begin
    next_rdata = 32'h0;
    case (addr_in)
      `REG_RUN:        next_rdata[NCH-1:0] = channel_run_bits;
      `REG_CTRL0, `REG_CTRL1, `REG_CTRL2: begin
        for (int k = 0; k < NCH; k++) begin
          if (addr_in == `REG_CTRL0 + 8'(4 * k)) begin
            next_rdata[`CTRL_SRC_LSB +: 2] = count_source[k];
            next_rdata[`CTRL_UNDERFLOW_IRQ_ENABLE_BIT]     = underflow_irq_enable[k];
            next_rdata[`CTRL_UNF_BIT]      = underflow_flag[k];
          end
        end
        if (addr_in == `REG_CTRL2) begin
          next_rdata[`CTRL_ICPE_LSB +: 2]  = capture_enable_bits;
          next_rdata[`CTRL_ICPIE_BIT]      = capture_irq_enable;
          next_rdata[`CTRL_ICPF_BIT]       = capture_flag;
        end
      end
      `REG_RELOAD0:    next_rdata = 32'(reload_constant_reg[0]);
      `REG_RELOAD1:    next_rdata = 32'(reload_constant_reg[1]);
      `REG_RELOAD2:    next_rdata = 32'(reload_constant_reg[2]);
      `REG_COUNT0:     next_rdata = 32'(down_counter[0]); // R9
      `REG_COUNT1:     next_rdata = 32'(down_counter[1]); // R9
      `REG_COUNT2:     next_rdata = 32'(down_counter[2]); // R9
      `REG_CAPTURE2:   next_rdata = 32'(capture_value_reg);
      `REG_IRQ_STATUS: next_rdata[3:0] = irq_status;
      `REG_IRQ_ENABLE: next_rdata[3:0] = irq_enable;
      `REG_SOURCE_CODE: next_rdata[11:0] = exception_source_code_out;
      default:         next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0;
    end else if (read_in) begin
      rdata_out <= next_rdata; // R9
    end else begin
      rdata_out <= 32'h0;
    end
  end
endmodule // timer_unit

// ===== tb/timer_unit_props.sv
// Checker of interrupt, source code and read port relations of the timer.
`include "timer_unit_regs.svh"
module timer_unit_props (
  input wire logic               clk_in,
  input wire logic               reset_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [31:0]        wdata_in,
  input wire logic               write_in,
  input wire logic               read_in,
  input wire logic               rtc_tick_in,
  input wire logic               timer_ext_pin_in,
  input wire logic [31:0]        rdata_out,
  input wire logic               underflow_irq_ch0_out,
  input wire logic               underflow_irq_ch1_out,
  input wire logic               underflow_irq_ch2_out,
  input wire logic               capture_irq_ch2_out,
  input wire logic [11:0]        exception_source_code_out,
  input wire logic               irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [3:0] reqs;
  assign reqs = {capture_irq_ch2_out, underflow_irq_ch2_out,
                 underflow_irq_ch1_out, underflow_irq_ch0_out};
  sequence s_ch0_held;
    underflow_irq_ch0_out [*2];
  endsequence
  sequence s_ch1_top;
    (underflow_irq_ch1_out && !underflow_irq_ch0_out) [*2];
  endsequence
  sequence s_quiet;
    !irq_out [*2];
  endsequence
  property p_or;
    irq_out == (|reqs);
  endproperty
  a_or: assert property (p_or) else $error("irq not OR of requests");
  property p_prio0;
    s_ch0_held |-> exception_source_code_out == `CODE_UNDERFLOW0;
  endproperty
  a_prio0: assert property (p_prio0) else $error("ch0 code wrong");
  property p_prio1;
    s_ch1_top |-> exception_source_code_out == `CODE_UNDERFLOW1;
  endproperty
  a_prio1: assert property (p_prio1) else $error("ch1 code wrong");
  property p_idle_code;
    s_quiet |-> exception_source_code_out == `CODE_NONE;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("stale code");
  property p_code_cause;
    exception_source_code_out != `CODE_NONE |-> $past(irq_out);
  endproperty
  a_code_cause: assert property (p_code_cause) else $error("code no req");
  property p_keep0;
    underflow_irq_ch0_out && !write_in |=> underflow_irq_ch0_out;
  endproperty
  a_keep0: assert property (p_keep0) else $error("ch0 request lost");
  property p_rdata_idle;
    !read_in |=> rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata held");
  property p_status;
    read_in && addr_in == `REG_IRQ_STATUS
      |=> (rdata_out[3:0] & $past(reqs)) == $past(reqs);
  endproperty
  a_status: assert property (p_status) else $error("status lacks flag");
  property p_run_rsv;
    read_in && addr_in == `REG_RUN |=> rdata_out[31:3] == 29'h0;
  endproperty
  a_run_rsv: assert property (p_run_rsv) else $error("run upper bits");
  sequence s_cap_alone;
    (capture_irq_ch2_out && !underflow_irq_ch0_out &&
     !underflow_irq_ch1_out && !underflow_irq_ch2_out) [*2];
  endsequence
  property p_prio_cap;
    s_cap_alone |-> exception_source_code_out == `CODE_CAPTURE2;
  endproperty
  a_prio_cap: assert property (p_prio_cap) else $error("cap code");
endmodule // timer_unit_props
bind timer_unit timer_unit_props i_props (.clk_in(clk_in),
  .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .write_in(write_in), .read_in(read_in), .rtc_tick_in(rtc_tick_in),
  .timer_ext_pin_in(timer_ext_pin_in), .rdata_out(rdata_out),
  .underflow_irq_ch0_out(underflow_irq_ch0_out),
  .underflow_irq_ch1_out(underflow_irq_ch1_out),
  .underflow_irq_ch2_out(underflow_irq_ch2_out),
  .capture_irq_ch2_out(capture_irq_ch2_out),
  .exception_source_code_out(exception_source_code_out),
  .irq_out(irq_out));

// ===== tb/cpu_bus_model.sv
// Processor side master of the timer register port.
module cpu_bus_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             write_out,
  output logic             read_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out  = 8'h0;
    wdata_out = 32'h0;
    write_out = 1'b0;
    read_out  = 1'b0;
  end
  // Released lines flip so a stale address is never mistaken for a valid one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clk_in);
    write_out <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd2(input logic [7:0] a, input int n,
                     output logic [31:0] d1, output logic [31:0] d2);
    @(posedge clk_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clk_in);
    if (n == 1) begin
      read_out <= 1'b0;
      addr_out <= ~a;
    end
    #1 d1 = rdata_in;
    d2 = d1;
    if (n == 2) begin
      @(posedge clk_in);
      read_out <= 1'b0;
      addr_out <= ~a;
      #1 d2 = rdata_in;
    end
  endtask
endmodule // cpu_bus_model

// ===== tb/tb_top.sv
// Self-checking bench for the timer unit interrupt and register logic.
`include "timer_unit_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_in, rtc_tick_in, timer_ext_pin_in;
  logic        write_in, read_in, irq0, irq1, irq2, cap, irq;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, d1, d2, k;
  logic [11:0] code;
  int          num_errors = 0;
  int          comparisons = 0;
  cpu_bus_model m (.clk_in(clk_in), .rdata_in(rdata_out),
    .addr_out(addr_in), .wdata_out(wdata_in), .write_out(write_in),
    .read_out(read_in));
  timer_unit i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
    .read_in(read_in), .rtc_tick_in(rtc_tick_in),
    .timer_ext_pin_in(timer_ext_pin_in), .rdata_out(rdata_out),
    .underflow_irq_ch0_out(irq0), .underflow_irq_ch1_out(irq1),
    .underflow_irq_ch2_out(irq2), .capture_irq_ch2_out(cap),
    .exception_source_code_out(code), .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    rtc_tick_in      <= 1'($urandom);
    timer_ext_pin_in <= 1'($urandom);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, lo, hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Expected source code: the lowest pending request index wins.
  function automatic logic [31:0] code_for(input logic [3:0] req);
    if (req[0]) return 32'(`CODE_UNDERFLOW0);
    if (req[1]) return 32'(`CODE_UNDERFLOW1);
    if (req[2]) return 32'(`CODE_UNDERFLOW2);
    if (req[3]) return 32'(`CODE_CAPTURE2);
    return 32'(`CODE_NONE);
  endfunction
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic print_verdict;
    $display("counts: %0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    print_verdict();
  end
  initial begin
    reset_in = 1'b1;
    void'($urandom(82));
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    m.rd2(`REG_COUNT0, 1, d1, d2);
    chk(d1, `COUNT_RESET);
    m.rd2(`REG_RELOAD2, 1, d1, d2);
    chk(d1, `RELOAD_RESET);
    m.rd2(`REG_IRQ_STATUS, 1, d1, d2);
    chk(d1, 32'h0);
    m.rd2(`REG_RUN, 1, d1, d2);
    chk(d1, 32'h0);
    m.rd2(8'hfc, 1, d1, d2);
    chk(d1, 32'h0);
    chk({19'h0, code, irq}, 32'h0);
    $display("test reset done");
    m.wr(`REG_IRQ_ENABLE, 32'hf);
    for (int n = 0; n < 4; n++) begin
      k = (n == 0) ? 32'h0 : 32'($urandom_range(12, 1));
      m.wr(`REG_RUN, 32'h0);
      m.wr(`REG_RELOAD0, 32'h1000 + k);
      m.wr(`REG_COUNT0, k);
      m.wr(`REG_CTRL0, 32'h20);
      m.wr(`REG_RUN, 32'h1);
      for (int i = 0; i < 40 && irq0 !== 1'b1; i++) tick();
      chk({cap, irq2, irq1, irq0}, 32'h1);
      m.rd2(`REG_COUNT0, 1, d1, d2);
      chk_in(d1, 32'h1000 + k - 40, 32'h1000 + k);
      m.rd2(`REG_COUNT0, 2, d1, d2);
      chk(d2, d1 - 32'h1);
      chk(code, code_for(4'h1));
      m.wr(`REG_RUN, 32'h0);
      m.wr(`REG_CTRL0, 32'h120);
      tick();
      chk(irq0, 1'b1);
      m.wr(`REG_CTRL0, 32'h20);
      tick();
      chk(irq0, 1'b0);
      $display("test underflow %0d done", n);
    end
    m.wr(`REG_COUNT0, 32'h5);
    m.wr(`REG_COUNT1, 32'h3);
    m.wr(`REG_COUNT2, 32'h1);
    m.wr(`REG_CTRL1, 32'h20);
    m.wr(`REG_CTRL2, 32'h20);
    m.wr(`REG_RUN, 32'h7);
    repeat (12) tick();
    m.wr(`REG_RUN, 32'h0);
    m.wr(`REG_IRQ_ENABLE, 32'h0);
    tick();
    chk(irq, 1'b0);
    m.rd2(`REG_IRQ_STATUS, 1, d1, d2);
    chk(d1, 32'h7);
    m.wr(`REG_IRQ_ENABLE, 32'hf);
    for (int c = 0; c < 3; c++) begin
      tick();
      chk(code, code_for(4'(4'h7 << c)));
      m.wr(`REG_IRQ_CLEAR, 32'h1 << c);
    end
    tick();
    chk({19'h0, code, irq}, 32'h0);
    $display("test priority done");
    // Channel zero counts pin rising edges, channel one counts RTC ticks.
    m.wr(`REG_COUNT0, 32'h2);
    m.wr(`REG_COUNT1, 32'h2);
    m.wr(`REG_CTRL0, 32'h22);
    m.wr(`REG_CTRL1, 32'h23);
    m.wr(`REG_RUN, 32'h3);
    for (int i = 0; i < 80 && {irq1, irq0} !== 2'h3; i++) tick();
    m.wr(`REG_RUN, 32'h0);
    chk({cap, irq2, irq1, irq0}, 32'h3);
    chk(code, code_for(4'h3));
    m.wr(`REG_IRQ_CLEAR, 32'h1);
    tick();
    chk(code, code_for(4'h2));
    // An RTC-clocked flag is cleared by writing and reading back until gone.
    d1 = 32'h1 << `CTRL_UNF_BIT;
    for (int i = 0; i < 4 && d1[`CTRL_UNF_BIT] !== 1'b0; i++) begin
      m.wr(`REG_CTRL1, 32'h23);
      m.rd2(`REG_CTRL1, 1, d1, d2);
    end
    chk(d1[`CTRL_UNF_BIT], 1'b0);
    chk(irq, 1'b0);
    $display("test pin and rtc sources done");
    // Channel two on the prescaled clock, capture on pin rising edges.
    m.wr(`REG_COUNT2, 32'h100);
    m.wr(`REG_CTRL2, 32'h541);
    m.wr(`REG_RUN, 32'h4);
    for (int i = 0; i < 40 && cap !== 1'b1; i++) tick();
    m.wr(`REG_RUN, 32'h0);
    chk({cap, irq2, irq1, irq0}, 32'h8);
    chk(code, code_for(4'h8));
    m.rd2(`REG_CAPTURE2, 1, d1, d2);
    chk_in(d1, 32'he0, 32'h100);
    m.wr(`REG_CTRL2, 32'h701);
    tick();
    chk(cap, 1'b1);
    m.wr(`REG_IRQ_CLEAR, 32'h8);
    tick();
    chk(cap, 1'b0);
    $display("test capture done");
    print_verdict();
  end
endmodule // tb_top
